// ==== logic/acs_sequencer.sv ====
/*
  Calibration sequencer for a three-core interleaved converter, with a
  Wishbone register slave, trigger handling and core routing.
  Assumes SYS_CLK is the sampling-domain clock and RESETN is power-up reset.
*/
// Decided for this implementation: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module acs_sequencer #(
  parameter int CORE_CAL_CYC = acs_pkg::CORE_CAL_CYC,
  parameter int FOREGROUND_OFFSET_CALIBRATION_CYC = acs_pkg::FOREGROUND_OFFSET_CALIBRATION_CYC,
  parameter int DLY_TICK_CYC = acs_pkg::DLY_TICK_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  input wire logic CALIBRATION_TRIGGER_PIN,
  input wire logic [11:0] SAMPLE_CORE_A,
  input wire logic [11:0] SAMPLE_CORE_B,
  input wire logic [11:0] SAMPLE_CORE_C,
  input wire logic [11:0] OFFSET_ESTIMATE,
  output logic [11:0] DATA_OUT_A,
  output logic [11:0] DATA_OUT_B,
  output logic [2:0] CORE_ONLINE,
  output logic [2:0] CORE_POWER,
  output logic [2:0] CORE_IN_SEL_B,
  output logic [5:0] BANK_PHASE,
  output logic [2:0] CORE_CAL_ACTIVE,
  output logic OFFSET_CAL_ACTIVE
);
  localparam int CW = 24;
  acs_pkg::acs_state_t state;
  logic [31:0] ctrl, dat_q;
  logic soft_trig;
  logic [15:0] sleep_dly;
  logic [15:0] wake_dly;
  logic done_flag;
  logic trig_meta, trig_sync, trig_prev, soft_prev;
  logic trig_rise;
  logic [CW-1:0] cnt;
  logic [5:0] tick_cnt;
  logic tick;
  logic target_b;
  logic swap_hold;
  logic [11:0] hold_a, hold_b;
  logic wb_hit, wb_wr, rd_trim_q;
  logic [1:0] trim_idx;
  logic trim_we_sw, trim_we;
  logic [1:0] trim_waddr;
  logic [11:0] trim_wdata, trim_rdata;
  logic os_busy;
  logic fg_os_done;

  // byte-lane write of one 32-bit word under sel
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) old[8*i +: 8] = nw[8*i +: 8];
    end
    return old;
  endfunction

  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O; // write lands at the ack edge
  assign trim_idx = WB_ADR_I[3:2];
  assign os_busy = ctrl[acs_pkg::CTRL_FG_OS] || ctrl[acs_pkg::CTRL_BG_OS];

  // pin synchroniser: only the second and third stages are looked at
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
      soft_prev <= 1'b0;
    end else begin
      trig_meta <= CALIBRATION_TRIGGER_PIN;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
      soft_prev <= soft_trig;
    end
  end

  // edge of the selected source, never its level
  assign trig_rise = ctrl[acs_pkg::CTRL_PIN_SEL] ? (trig_sync && !trig_prev)
                                                 : (soft_trig && !soft_prev);

  // slow tick for the sleep and wake delays
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 6'h01;
    end
  end
  assign tick = (tick_cnt == 6'(DLY_TICK_CYC - 1));

  // wishbone ack, one cycle per request
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_hit;
    end
  end

  // configuration registers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl <= acs_pkg::CTRL_RESET;
      soft_trig <= 1'b0;
      sleep_dly <= acs_pkg::SLEEP_RESET;
      wake_dly <= acs_pkg::WAKE_RESET;
    end else if (wb_wr) begin
      case (WB_ADR_I)
        acs_pkg::ADDR_CTRL: ctrl <= merge(ctrl, WB_DAT_I, WB_SEL_I) & 32'h0000_00FF;
        acs_pkg::ADDR_TRIG: if (WB_SEL_I[0]) soft_trig <= WB_DAT_I[acs_pkg::TRIG_SOFT];
        acs_pkg::ADDR_LP: begin
          if (WB_SEL_I[0]) sleep_dly[7:0] <= WB_DAT_I[7:0];
          if (WB_SEL_I[1]) sleep_dly[15:8] <= WB_DAT_I[15:8];
          if (WB_SEL_I[2]) wake_dly[7:0] <= WB_DAT_I[23:16];
          if (WB_SEL_I[3]) wake_dly[15:8] <= WB_DAT_I[31:24];
        end
        default: ;
      endcase
    end
  end

  // read mux; trims go through the registered memory port
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dat_q <= '0;
      rd_trim_q <= 1'b0;
    end else if (wb_hit && !WB_WE_I) begin
      rd_trim_q <= (WB_ADR_I[7:4] == acs_pkg::ADDR_TRIM0[7:4]);
      case (WB_ADR_I)
        acs_pkg::ADDR_CTRL: dat_q <= ctrl;
        acs_pkg::ADDR_TRIG: dat_q <= {31'h0, soft_trig};
        acs_pkg::ADDR_LP: dat_q <= {wake_dly, sleep_dly};
        acs_pkg::ADDR_STAT: dat_q <= {26'h0, target_b, state, done_flag, fg_os_done};
        default: dat_q <= 32'h0;
      endcase
    end
  end
  // trim word taken from the memory's own output register, no extra wait state
  assign WB_DAT_O = rd_trim_q ? {20'h0, trim_rdata} : dat_q;

  // trims: same-cycle registered read lands in the low bits
  assign trim_we_sw = wb_wr && (WB_ADR_I[7:4] == acs_pkg::ADDR_TRIM0[7:4])
                      && WB_SEL_I[0] && !os_busy;
  assign trim_we = trim_we_sw || (OFFSET_CAL_ACTIVE && cnt == '0);
  assign trim_waddr = trim_we_sw ? trim_idx : {1'b0, target_b};
  assign trim_wdata = trim_we_sw ? WB_DAT_I[11:0] : OFFSET_ESTIMATE;

  acs_trim_mem #(.DEPTH(acs_pkg::NTRIM), .WIDTH(12)) u_trim (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .we(trim_we),
    .waddr(trim_waddr),
    .wdata(trim_wdata),
    .raddr(trim_idx),
    .rdata(trim_rdata)
  );

  // sequencer: power-up foreground run, then triggered or background loop
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= acs_pkg::S_FG_CORE;
      cnt <= CW'(CORE_CAL_CYC - 1);
      done_flag <= 1'b0;
      fg_os_done <= 1'b0;
      target_b <= 1'b0;
    end else begin
      case (state)
        acs_pkg::S_IDLE: begin
          if (ctrl[acs_pkg::CTRL_BG_EN] && trig_rise) begin
            state <= ctrl[acs_pkg::CTRL_LOW_POWER_BACKGROUND_ENABLE] ? acs_pkg::S_BG_SLEEP : acs_pkg::S_BG_CAL;
            cnt <= ctrl[acs_pkg::CTRL_LOW_POWER_BACKGROUND_ENABLE] ? CW'(sleep_dly) : CW'(CORE_CAL_CYC - 1);
          end else if (trig_rise) begin
            state <= acs_pkg::S_FG_CORE;
            cnt <= CW'(CORE_CAL_CYC - 1);
            done_flag <= 1'b0;
            fg_os_done <= 1'b0;
          end
        end
        acs_pkg::S_FG_CORE: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (ctrl[acs_pkg::CTRL_FG_OS]) begin
            state <= acs_pkg::S_FG_OS;
            cnt <= CW'(FOREGROUND_OFFSET_CALIBRATION_CYC - 1);
          end else begin
            state <= acs_pkg::S_IDLE;
            done_flag <= 1'b1;
          end
        end
        acs_pkg::S_FG_OS: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (!target_b) begin
            target_b <= 1'b1;
            cnt <= CW'(FOREGROUND_OFFSET_CALIBRATION_CYC - 1);
          end else begin
            target_b <= 1'b0;
            state <= acs_pkg::S_IDLE;
            done_flag <= 1'b1;
            fg_os_done <= 1'b1;
          end
        end
        acs_pkg::S_BG_SLEEP: begin
          // automatic: count sleep ticks; user: wait for next trigger edge
          if (!ctrl[acs_pkg::CTRL_BG_EN]) begin
            state <= acs_pkg::S_IDLE;
          end else if (ctrl[acs_pkg::CTRL_LP_SW] ? trig_rise : (cnt == '0)) begin
            state <= acs_pkg::S_BG_WAKE;
            cnt <= CW'(wake_dly);
          end else if (tick && cnt != '0) begin
            cnt <= cnt - 1'b1;
          end
        end
        acs_pkg::S_BG_WAKE: begin
          if (cnt == '0) begin
            state <= acs_pkg::S_BG_CAL;
            cnt <= CW'(CORE_CAL_CYC - 1);
          end else if (tick) begin
            cnt <= cnt - 1'b1;
          end
        end
        acs_pkg::S_BG_CAL: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= acs_pkg::S_BG_SWAP;
          end
        end
        acs_pkg::S_BG_SWAP: begin
          target_b <= !target_b;
          if (!ctrl[acs_pkg::CTRL_BG_EN]) begin
            state <= acs_pkg::S_IDLE;
          end else if (ctrl[acs_pkg::CTRL_LOW_POWER_BACKGROUND_ENABLE]) begin
            state <= acs_pkg::S_BG_SLEEP;
            cnt <= CW'(sleep_dly);
          end else begin
            state <= acs_pkg::S_BG_CAL;
            cnt <= CW'(CORE_CAL_CYC - 1);
          end
        end
        default: state <= acs_pkg::S_IDLE;
      endcase
    end
  end

  // offset engine runs in foreground pass or during every background cycle
  assign OFFSET_CAL_ACTIVE = (state == acs_pkg::S_FG_OS)
                             || (state == acs_pkg::S_BG_CAL && ctrl[acs_pkg::CTRL_BG_OS]);

  // swap glitch limited to one held sample at the hand-over
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      swap_hold <= 1'b0;
    end else begin
      swap_hold <= (state == acs_pkg::S_BG_SWAP);
    end
  end

  // output routing: spare core C stands in for the core under calibration
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      hold_a <= acs_pkg::MIDCODE;
      hold_b <= acs_pkg::MIDCODE;
    end else if (state == acs_pkg::S_FG_CORE || state == acs_pkg::S_FG_OS) begin
      hold_a <= acs_pkg::MIDCODE;
      hold_b <= acs_pkg::MIDCODE;
    end else if (!swap_hold) begin
      hold_a <= (state == acs_pkg::S_BG_CAL && !target_b) ? SAMPLE_CORE_C : SAMPLE_CORE_A;
      hold_b <= (state == acs_pkg::S_BG_CAL && target_b) ? SAMPLE_CORE_C : SAMPLE_CORE_B;
    end
  end
  assign DATA_OUT_A = hold_a;
  assign DATA_OUT_B = hold_b;

  // core status and input selection
  always_comb begin
    CORE_ONLINE = 3'b011;
    CORE_CAL_ACTIVE = 3'b000;
    CORE_POWER = 3'b111;
    case (state)
      acs_pkg::S_FG_CORE, acs_pkg::S_FG_OS: begin
        CORE_ONLINE = 3'b000;
        CORE_CAL_ACTIVE = 3'b011;
      end
      acs_pkg::S_BG_SLEEP: CORE_POWER = 3'b011;
      acs_pkg::S_BG_CAL: begin
        CORE_ONLINE = target_b ? 3'b101 : 3'b110;
        CORE_CAL_ACTIVE = target_b ? 3'b010 : 3'b001;
      end
      acs_pkg::S_IDLE: if (ctrl[acs_pkg::CTRL_BG_EN] && ctrl[acs_pkg::CTRL_LOW_POWER_BACKGROUND_ENABLE]) CORE_POWER = 3'b011;
      default: ;
    endcase
  end

  // dual: A on input A, B on input B; single: both on the chosen input
  assign CORE_IN_SEL_B[0] = !ctrl[acs_pkg::CTRL_DUAL] && ctrl[acs_pkg::CTRL_SEL_B];
  assign CORE_IN_SEL_B[1] = ctrl[acs_pkg::CTRL_DUAL] || ctrl[acs_pkg::CTRL_SEL_B];
  assign CORE_IN_SEL_B[2] = target_b ? CORE_IN_SEL_B[1] : CORE_IN_SEL_B[0];

  // banks of each core sample on opposite phases, six banks in all
  assign BANK_PHASE = 6'b10_10_10;

endmodule // acs_sequencer

// ==== logic/acs_pkg.sv ====
/*
  Package for the converter core calibration sequencer: Wishbone register
  offsets, field positions, reset values, timing counts and the state type.
  Assumes a 40 MHz system clock and a 32-bit classic Wishbone bus.
*/
package acs_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIG = 8'h04;
  localparam logic [7:0] ADDR_LP = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_TRIM0 = 8'h10;
  // control field positions
  localparam int CTRL_BG_EN = 0;
  localparam int CTRL_PIN_SEL = 1;
  localparam int CTRL_LOW_POWER_BACKGROUND_ENABLE = 2;
  localparam int CTRL_LP_SW = 3;
  localparam int CTRL_FG_OS = 4;
  localparam int CTRL_BG_OS = 5;
  localparam int CTRL_DUAL = 6;
  localparam int CTRL_SEL_B = 7;
  localparam int TRIG_SOFT = 0;
  // low-power delay field positions
  localparam int LP_SLEEP_LSB = 0;
  localparam int LP_WAKE_LSB = 16;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0040;
  localparam logic [15:0] SLEEP_RESET = 16'h0100;
  localparam logic [15:0] WAKE_RESET = 16'h0040;
  localparam logic [11:0] TRIM_FACTORY = 12'h800;
  localparam logic [11:0] MIDCODE = 12'h000;
  // timing: calibration steps in cycles of the 40 MHz clock
  localparam int CLK_MHZ = 40;
  localparam int CORE_CAL_US = 50;
  localparam int CORE_CAL_CYC = CORE_CAL_US * CLK_MHZ;
  localparam int FOREGROUND_OFFSET_CALIBRATION_US = 80;
  localparam int FOREGROUND_OFFSET_CALIBRATION_CYC = FOREGROUND_OFFSET_CALIBRATION_US * CLK_MHZ;
  localparam int DLY_TICK_CYC = 64;
  localparam int NTRIM = 4;
  // sequencer states, gray from S_IDLE through S_FG_CORE to S_FG_OS, not on the return to S_IDLE
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FG_CORE = 3'b001,
    S_FG_OS = 3'b011,
    S_BG_SLEEP = 3'b010,
    S_BG_WAKE = 3'b110,
    S_BG_CAL = 3'b111,
    S_BG_SWAP = 3'b101
  } acs_state_t;
endpackage

// ==== logic/acs_trim_mem.sv ====
/*
  Small trim memory holding the input offset trim words, registered read.
  Assumes one write port shared by software and the offset engine.
*/
`timescale 1ns/100ps
module acs_trim_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // words come up at the factory value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= acs_pkg::TRIM_FACTORY;
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // acs_trim_mem

// ==== dv/acs_seq_sva.sv ====
/*
  Port checker for the calibration sequencer, bound to every instance.
  Assumes the sequencer parameters are handed on by the bind below.
*/
`timescale 1ns/100ps
module acs_seq_sva #(
  parameter int CORE_CAL_CYC = 2000,
  parameter int FOREGROUND_OFFSET_CALIBRATION_CYC = 3200,
  parameter int DLY_TICK_CYC = 64
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [11:0] DATA_OUT_A,
  input wire logic [11:0] DATA_OUT_B,
  input wire logic [2:0] CORE_ONLINE,
  input wire logic [2:0] CORE_POWER,
  input wire logic [2:0] CORE_CAL_ACTIVE,
  input wire logic [5:0] BANK_PHASE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  // two cycles of foreground cal: the output register has seen midcode
  fg_midcode_a: assert property (
    CORE_CAL_ACTIVE == 3'b011 && $past(CORE_CAL_ACTIVE) == 3'b011
    |-> DATA_OUT_A == 12'h000 && DATA_OUT_B == 12'h000) else $error("output not midcode");
  fg_offline_a: assert property (
    CORE_CAL_ACTIVE == 3'b011 |-> CORE_ONLINE == 3'b000) else $error("core online in fg");
  // one core in background cal leaves the other two carrying data
  bg_online_a: assert property (
    $countones(CORE_CAL_ACTIVE) == 1 |-> $countones(CORE_ONLINE) == 2)
    else $error("data path lost a core");
  cal_offline_a: assert property (
    (CORE_CAL_ACTIVE & CORE_ONLINE) == 3'b000) else $error("core online while calibrating");
  pwr_online_a: assert property (
    ((CORE_ONLINE | CORE_CAL_ACTIVE) & ~CORE_POWER) == 3'b000) else $error("unpowered core used");
  bank_phase_a: assert property (
    BANK_PHASE == 6'b101010) else $error("bank phases wrong");
  // bus answer is a single fixed-latency pulse inside a live cycle
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  ack_req_a: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack missing");
  ack_cyc_a: assert property (WB_ACK_O |-> WB_CYC_I && WB_STB_I) else $error("ack without cycle");
endmodule // acs_seq_sva

bind acs_sequencer acs_seq_sva #(.CORE_CAL_CYC(CORE_CAL_CYC), .FOREGROUND_OFFSET_CALIBRATION_CYC(FOREGROUND_OFFSET_CALIBRATION_CYC),
  .DLY_TICK_CYC(DLY_TICK_CYC)) u_sva (.SYS_CLK, .RESETN, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
  .DATA_OUT_A, .DATA_OUT_B, .CORE_ONLINE, .CORE_POWER, .CORE_CAL_ACTIVE, .BANK_PHASE);

// ==== dv/acs_core_model.sv ====
/*
  Behavioural model of the three converter cores behind the sequencer.
  Assumes the sequencer power outputs gate each core.
*/
`timescale 1ns/100ps
module acs_core_model (
  input wire logic clk,
  input wire logic [2:0] power,
  output logic [11:0] sample_a,
  output logic [11:0] sample_b,
  output logic [11:0] sample_c,
  output logic [11:0] offset_estimate
);
  logic [11:0] cnt = 12'h001;
  initial sample_a = 12'h555;
  initial sample_b = 12'h555;
  initial sample_c = 12'h555;
  // input kept quiet, so the estimate is a small fixed offset
  assign offset_estimate = 12'h013;
  // ramp per core; a sleeping core toggles so stale data never passes
  always @(posedge clk) begin
    cnt <= cnt + 12'h001;
    sample_a <= power[0] ? cnt : ~sample_a;
    sample_b <= power[1] ? cnt + 12'h100 : ~sample_b;
    sample_c <= power[2] ? cnt + 12'h200 : ~sample_c;
  end
endmodule // acs_core_model

// ==== dv/tb_top.sv ====
/*
  Self-checking bench for the calibration sequencer: Wishbone tasks, power-up,
  triggers, routing, background and low-power runs.
  Assumes the core model and the bound port checker.
*/
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic pin = 1'b0;
  logic osd = 1'b0;
  logic ack;
  logic [31:0] dat_o;
  logic [11:0] sa, sb, sc, ofs, oa, ob;
  logic [2:0] online, power, selb, calact;
  logic [5:0] bank;
  logic osact;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int os_rise = 0;
  int n_c = 0;
  int n_fg = 0;
  int n_sleep = 0;
  int n_cal = 0;
  int n_ca = 0;
  int b1, b2, b3, b4;

  acs_sequencer #(.CORE_CAL_CYC(20), .FOREGROUND_OFFSET_CALIBRATION_CYC(20), .DLY_TICK_CYC(4)) DUT (
    .SYS_CLK(sys_clk), .RESETN(resetn), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_ACK_O(ack),
    .CALIBRATION_TRIGGER_PIN(pin), .SAMPLE_CORE_A(sa), .SAMPLE_CORE_B(sb),
    .SAMPLE_CORE_C(sc), .OFFSET_ESTIMATE(ofs), .DATA_OUT_A(oa), .DATA_OUT_B(ob),
    .CORE_ONLINE(online), .CORE_POWER(power), .CORE_IN_SEL_B(selb), .BANK_PHASE(bank),
    .CORE_CAL_ACTIVE(calact), .OFFSET_CAL_ACTIVE(osact));
  acs_core_model u_cores (.clk(sys_clk), .power(power), .sample_a(sa), .sample_b(sb),
    .sample_c(sc), .offset_estimate(ofs));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // event counters; tests compare snapshots so no clearing race
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    osd <= osact;
    if (osact === 1'b1 && osd === 1'b0) os_rise <= os_rise + 1;
    if (online[2] === 1'b1) n_c <= n_c + 1;
    if (calact === 3'b011) n_fg <= n_fg + 1;
    if (power !== 3'b111) n_sleep <= n_sleep + 1;
    if (calact !== 3'b000) n_cal <= n_cal + 1;
    // core C ramp sits 0x100 above core B only while C carries path A
    if (oa - ob == 12'h100) n_ca <= n_ca + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // classic single cycle; held until ack, released at that edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    do @(posedge sys_clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_done();
    rdat = 32'h0;
    while (rdat[1] !== 1'b1) wb(acs_pkg::ADDR_STAT, 1'b0, 32'h0);
  endtask

  // the software trigger acts on a 0 to 1 change only
  task automatic soft_trig();
    wb(acs_pkg::ADDR_TRIG, 1'b1, 32'h0);
    wb(acs_pkg::ADDR_TRIG, 1'b1, 32'h1);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk("powerup cal", calact, 3'b011);
    chk("powerup data", oa, 12'h000);
    chk("bank phase", bank, 6'b101010);
    wb(acs_pkg::ADDR_STAT, 1'b0, 32'h0);
    chk("done clear", rdat[1], 1'b0);
    wait_done();
    wb(acs_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", rdat, acs_pkg::CTRL_RESET);
    wb(acs_pkg::ADDR_LP, 1'b0, 32'h0);
    chk("lp reset", rdat, {acs_pkg::WAKE_RESET, acs_pkg::SLEEP_RESET});
    wb(acs_pkg::ADDR_TRIM0, 1'b0, 32'h0);
    chk("trim reset", rdat, 32'(acs_pkg::TRIM_FACTORY));
    wb(8'h3C, 1'b1, 32'hFFFF_FFFF);
    wb(8'h3C, 1'b0, 32'h0);
    chk("unmapped", rdat, 32'h0);
    // input routing: dual, single on B, single on A
    @(negedge sys_clk);
    chk("dual route", selb, 3'b010);
    wb(acs_pkg::ADDR_CTRL, 1'b1, 32'h80);
    @(negedge sys_clk);
    chk("single b", selb, 3'b111);
    wb(acs_pkg::ADDR_CTRL, 1'b1, 32'h00);
    @(negedge sys_clk);
    chk("single a", selb, 3'b000);
    // foreground with one offset pass; enable set before the trigger
    wb(acs_pkg::ADDR_CTRL, 1'b1, 32'h50);
    b1 = os_rise;
    soft_trig();
    wb(acs_pkg::ADDR_STAT, 1'b0, 32'h0);
    chk("done cleared", rdat[1], 1'b0);
    wait_done();
    chk("os once", os_rise - b1, 1);
    chk("os done", rdat[0], 1'b1);
    // offset results read only once done; software writes refused while the offset enable is set
    wb(acs_pkg::ADDR_TRIM0, 1'b0, 32'h0);
    chk("trim a cal", rdat, 32'h0000_0013);
    wb(acs_pkg::ADDR_TRIM0 + 8'h04, 1'b0, 32'h0);
    chk("trim b cal", rdat, 32'h0000_0013);
    wb(acs_pkg::ADDR_TRIM0 + 8'h08, 1'b0, 32'h0);
    chk("trim spare", rdat, 32'(acs_pkg::TRIM_FACTORY));
    wb(acs_pkg::ADDR_TRIM0, 1'b1, 32'h0000_0123);
    wb(acs_pkg::ADDR_TRIM0, 1'b0, 32'h0);
    chk("trim locked", rdat, 32'h0000_0013);
    wb(acs_pkg::ADDR_TRIG, 1'b1, 32'h1);
    wb(acs_pkg::ADDR_STAT, 1'b0, 32'h0);
    chk("level no start", rdat[1], 1'b1);
    // pin selected: the software bit is ignored, the pin edge starts
    wb(acs_pkg::ADDR_CTRL, 1'b1, 32'h42);
    wb(acs_pkg::ADDR_TRIM0 + 8'h08, 1'b1, 32'h0000_05A5);
    wb(acs_pkg::ADDR_TRIM0 + 8'h08, 1'b0, 32'h0);
    chk("trim write", rdat, 32'h0000_05A5);
    soft_trig();
    repeat (6) @(negedge sys_clk);
    chk("soft ignored", calact === 3'b011, 1'b0);
    @(posedge sys_clk);
    pin <= 1'b1;
    repeat (6) @(negedge sys_clk);
    chk("pin start", calact, 3'b011);
    @(posedge sys_clk);
    pin <= 1'b0;
    wait_done();
    // background rotation with continuous offset correction
    wb(acs_pkg::ADDR_CTRL, 1'b1, 32'h61);
    b1 = n_fg;
    b2 = n_c;
    b3 = os_rise;
    b4 = n_ca;
    soft_trig();
    repeat (800) @(posedge sys_clk);
    chk("bg no fg", n_fg - b1, 0);
    chk("spare online", n_c > b2, 1'b1);
    chk("bg offset", os_rise > b3, 1'b1);
    chk("c for a", n_ca > b4, 1'b1);
    // low-power rotation, automatic switching, short sleep and wake
    wb(acs_pkg::ADDR_LP, 1'b1, 32'h0001_0002);
    wb(acs_pkg::ADDR_CTRL, 1'b1, 32'h45);
    // let the running full-power pass finish before snapshots
    repeat (50) @(posedge sys_clk);
    b1 = n_sleep;
    b2 = n_cal;
    repeat (800) @(posedge sys_clk);
    chk("spare asleep", n_sleep > b1, 1'b1);
    chk("spare cal", n_cal > b2, 1'b1);
    // user switching: the spare sleeps until the software edge
    wb(acs_pkg::ADDR_CTRL, 1'b1, 32'h4D);
    repeat (100) @(posedge sys_clk);
    b2 = n_cal;
    repeat (100) @(negedge sys_clk);
    chk("user waits", n_cal - b2, 0);
    chk("user asleep", power, 3'b011);
    soft_trig();
    repeat (60) @(posedge sys_clk);
    chk("user switch", n_cal > b2, 1'b1);
    summarize();
  end
endmodule // tb_top
